// [common/afe_link_if.sv]
// register and command link between controller and device
`timescale 1ns/1ps
interface afe_link_if (
    input wire logic ref_clk,
    input wire logic reset_n
);
    logic       reg_wr;
    logic       reg_rd;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       reg_rvalid;
    logic       cmd_valid;
    logic [2:0] cmd_code;
    logic       cal_busy;
    logic       ready_n;
    logic       result_discard;

    modport dev (input reg_wr, reg_rd, reg_addr, reg_wdata, cmd_valid, cmd_code,
                 output reg_rdata, reg_rvalid, cal_busy, ready_n, result_discard);
    modport ctl (output reg_wr, reg_rd, reg_addr, reg_wdata, cmd_valid, cmd_code,
                 input reg_rdata, reg_rvalid, cal_busy, ready_n, result_discard);
endinterface

// [common/afe_pkg.sv]
// shared constants for the converter front-end control ends
package afe_pkg;
    // device register addresses
    localparam logic [3:0] ADDR_SETUP = 4'h0;
    localparam logic [3:0] ADDR_MUX   = 4'h1;
    localparam logic [3:0] ADDR_ANA   = 4'h2;
    localparam logic [3:0] ADDR_DAC1  = 4'h3;
    localparam logic [3:0] ADDR_DAC2  = 4'h4;
    localparam logic [3:0] ADDR_OFS   = 4'h5;
    localparam logic [3:0] ADDR_PVAL  = 4'h6;
    localparam logic [3:0] ADDR_DIR   = 4'h7;
    localparam logic [3:0] ADDR_DEC0  = 4'h8;
    localparam logic [3:0] ADDR_DEC1  = 4'h9;
    // field positions
    localparam int SETUP_SPEED  = 4;
    localparam int SETUP_REF_EN = 3;
    localparam int SETUP_REF_HI = 2;
    localparam int SETUP_BUF    = 1;
    localparam int ANA_BURN     = 7;
    localparam int ANA_R2_LSB   = 5;
    localparam int ANA_R1_LSB   = 3;
    localparam int DEC1_RDY     = 7;
    localparam int DEC1_MODE    = 4;
    // reset values and the temperature mux code
    localparam logic [7:0] SETUP_RST = 8'h0C;
    localparam logic [7:0] DIR_RST   = 8'hFF;
    localparam logic [7:0] DEC0_RST  = 8'h80;
    localparam logic [7:0] DEC1_RST  = 8'h80;
    localparam logic [7:0] MUX_TEMP  = 8'hFF;
    // timing counts
    localparam logic [8:0] DIV_SLOW   = 9'h100;
    localparam logic [8:0] DIV_FAST   = 9'h080;
    localparam logic [4:0] CAL_SINGLE = 5'h07;
    localparam logic [4:0] CAL_DOUBLE = 5'h0E;
    // filter modes
    localparam logic [1:0] FLT_AUTO  = 2'h0;
    localparam logic [1:0] FLT_FAST  = 2'h1;
    localparam logic [1:0] FLT_SINC2 = 2'h2;
    localparam logic [1:0] FLT_SINC3 = 2'h3;
    // link commands
    typedef enum logic [2:0] {
        CMD_SELF_BOTH, CMD_SELF_GAIN, CMD_SELF_OFS,
        CMD_SYS_OFS, CMD_SYS_GAIN, CMD_DATA_TAKEN
    } afe_cmd_t;
    // apb offsets, op codes and event bits of the controller
    localparam logic [7:0] APB_OP     = 8'h00;
    localparam logic [7:0] APB_STATUS = 8'h04;
    localparam logic [7:0] APB_ISTAT  = 8'h08;
    localparam logic [7:0] APB_ICLR   = 8'h0C;
    localparam logic [7:0] APB_IEN    = 8'h10;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_CMD   = 2'h3;
    localparam int EV_CAL    = 0;
    localparam int EV_READ   = 1;
    localparam int EV_REFUSE = 2;
endpackage

// [logic/afe_device.sv]
// device end: configuration registers and conversion path control
// What this block does
// - all-ones mux code connects temperature diode
// - any channel pairs with any other channel
// - burnout bit enables source and sink
// - buffer on only when pin and bit
// - two current dacs, code and range
// - gain from 1 to 128
// - offset register is sign and magnitude
// - modulator divide by 128 or 256
// - three self calibration commands
// - seven periods single, fourteen combined
// - system calibrations take seven periods
// - calibration clears the offset register
// - host advises calibration after power or changes
// - ready goes low when calibration ends
// - filter fast, sinc2, sinc3 or auto
// - auto: fast twice, sinc2, then sinc3
// - reset selects internal 2.5V reference
// - digital pins are inputs after reset
// - direction, drive and read back pins
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
module afe_device
    import afe_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    afe_link_if.dev         link,
    input  wire logic       buffer_gate_pin,
    input  wire logic [7:0] gpio_in,
    output logic      [7:0] gpio_out,
    output logic      [7:0] gpio_oe,
    output logic            temp_diode_en,
    output logic      [3:0] pos_sel,
    output logic      [3:0] neg_sel,
    output logic            burnout_source,
    output logic            burnout_sink,
    output logic            input_buffer_en,
    output logic      [7:0] current_dac_one,
    output logic      [7:0] current_dac_two,
    output logic      [1:0] dac_one_range,
    output logic      [1:0] dac_two_range,
    output logic      [7:0] gain_amplifier,
    output logic            offset_sign,
    output logic      [6:0] offset_mag,
    output logic            modulator_clock,
    output logic            ref_internal,
    output logic            ref_high,
    output logic      [1:0] filter_sel,
    output logic            conversion_ready_n
);
    typedef enum logic {CAL_IDLE, CAL_RUN} afe_cal_t;

    logic [7:0]  setup, mux, analog_control_reg, dac1_code, dac2_code;
    logic [7:0]  input_offset_shift, pin_value_reg, dir;
    logic [7:0]  dec0, dec1;
    logic [7:0]  gate_s1, gate_s2;
    logic [7:0]  pin_s1, pin_s2;
    logic [8:0]  div_cnt;
    logic [10:0] mod_cnt;
    logic        data_tick;
    logic [4:0]  cal_left;
    logic [1:0]  conv_idx;
    afe_cal_t    cal_state;
    logic        cal_start;
    logic        cal_done;
    logic [1:0]  next_filter;

    function automatic logic [1:0] auto_filter(input logic [1:0] idx);
        unique case (idx)
            2'h0, 2'h1: auto_filter = FLT_FAST;
            2'h2:       auto_filter = FLT_SINC2;
            2'h3:       auto_filter = FLT_SINC3;
        endcase
    endfunction

    assign cal_start = link.cmd_valid && cal_state == CAL_IDLE
                       && link.cmd_code < CMD_DATA_TAKEN;
    assign cal_done  = cal_state == CAL_RUN && data_tick && cal_left == 5'h01;

    // pin synchronisers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            gate_s1 <= 8'h00;
            gate_s2 <= 8'h00;
            pin_s1  <= 8'h00;
            pin_s2  <= 8'h00;
        end else begin
            gate_s1 <= {7'h00, buffer_gate_pin};
            gate_s2 <= gate_s1;
            pin_s1  <= gpio_in;
            pin_s2  <= pin_s1;
        end
    end

    // register writes
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            setup <= SETUP_RST;
            mux   <= 8'h01;
            analog_control_reg <= 8'h00;
            dac1_code <= 8'h00;
            dac2_code <= 8'h00;
            input_offset_shift <= 8'h00;
            pin_value_reg <= 8'h00;
            dir   <= DIR_RST;
            dec0  <= DEC0_RST;
            dec1  <= DEC1_RST;
        end else if (cal_start) begin
            input_offset_shift <= 8'h00;
        end else if (link.reg_wr) begin
            unique case (link.reg_addr)
                ADDR_SETUP: setup <= link.reg_wdata;
                ADDR_MUX:   mux   <= link.reg_wdata;
                ADDR_ANA:   analog_control_reg <= link.reg_wdata;
                ADDR_DAC1:  dac1_code <= link.reg_wdata;
                ADDR_DAC2:  dac2_code <= link.reg_wdata;
                ADDR_OFS:   input_offset_shift <= link.reg_wdata;
                ADDR_PVAL:  pin_value_reg <= link.reg_wdata;
                ADDR_DIR:   dir   <= link.reg_wdata;
                ADDR_DEC0:  dec0  <= link.reg_wdata;
                ADDR_DEC1:  dec1  <= {1'b0, link.reg_wdata[6:0]};
                default: ;
            endcase
        end
    end

    // register reads
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            link.reg_rdata  <= 8'h00;
            link.reg_rvalid <= 1'b0;
        end else begin
            link.reg_rvalid <= link.reg_rd;
            if (link.reg_rd) begin
                unique case (link.reg_addr)
                    ADDR_SETUP: link.reg_rdata <= setup;
                    ADDR_MUX:   link.reg_rdata <= mux;
                    ADDR_ANA:   link.reg_rdata <= analog_control_reg;
                    ADDR_DAC1:  link.reg_rdata <= dac1_code;
                    ADDR_DAC2:  link.reg_rdata <= dac2_code;
                    ADDR_OFS:   link.reg_rdata <= input_offset_shift;
                    ADDR_PVAL:  link.reg_rdata <= (dir & pin_s2) | (~dir & pin_value_reg);
                    ADDR_DIR:   link.reg_rdata <= dir;
                    ADDR_DEC0:  link.reg_rdata <= dec0;
                    ADDR_DEC1:  link.reg_rdata <= {conversion_ready_n, dec1[6:0]};
                    default:    link.reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt         <= 9'h000;
            modulator_clock <= 1'b0;
        end else begin
            modulator_clock <= 1'b0;
            if (div_cnt >= (setup[SETUP_SPEED] ? DIV_SLOW : DIV_FAST) - 9'h001) begin
                div_cnt         <= 9'h000;
                modulator_clock <= 1'b1;
            end else begin
                div_cnt <= div_cnt + 9'h001;
            end
        end
    end

    // output data period from decimation
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mod_cnt   <= 11'h000;
            data_tick <= 1'b0;
        end else begin
            data_tick <= 1'b0;
            if (modulator_clock) begin
                if (mod_cnt >= {dec1[2:0], dec0} - 11'h001) begin
                    mod_cnt   <= 11'h000;
                    data_tick <= 1'b1;
                end else begin
                    mod_cnt <= mod_cnt + 11'h001;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cal_state     <= CAL_IDLE;
            cal_left      <= 5'h00;
            link.cal_busy <= 1'b0;
        end else begin
            unique case (cal_state)
                CAL_IDLE: if (cal_start) begin
                    cal_state     <= CAL_RUN;
                    link.cal_busy <= 1'b1;
                    cal_left      <= link.cmd_code == CMD_SELF_BOTH ? CAL_DOUBLE : CAL_SINGLE;
                end
                CAL_RUN: if (data_tick) begin
                    cal_left <= cal_left - 5'h01;
                    if (cal_done) begin
                        cal_state     <= CAL_IDLE;
                        link.cal_busy <= 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            conversion_ready_n <= 1'b1;
            link.ready_n       <= 1'b1;
        end else if (cal_done || (data_tick && cal_state == CAL_IDLE)) begin
            conversion_ready_n <= 1'b0;
            link.ready_n       <= 1'b0;
        end else if (cal_start || (link.cmd_valid && link.cmd_code == CMD_DATA_TAKEN)) begin
            conversion_ready_n <= 1'b1;
            link.ready_n       <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_idx            <= 2'h0;
            link.result_discard <= 1'b0;
        end else if (link.reg_wr && (link.reg_addr == ADDR_MUX || link.reg_addr == ADDR_ANA)) begin
            conv_idx <= 2'h0;
        end else if (data_tick) begin
            link.result_discard <= dec1[5:4] == FLT_AUTO && conv_idx == 2'h0;
            if (conv_idx != 2'h3) begin
                conv_idx <= conv_idx + 2'h1;
            end
        end
    end

    assign next_filter = dec1[5:4] == FLT_AUTO ? auto_filter(conv_idx) : dec1[5:4];

    // analog control outputs
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            temp_diode_en   <= 1'b0;
            pos_sel         <= 4'h0;
            neg_sel         <= 4'h0;
            burnout_source  <= 1'b0;
            burnout_sink    <= 1'b0;
            input_buffer_en <= 1'b0;
            current_dac_one <= 8'h00;
            current_dac_two <= 8'h00;
            dac_one_range   <= 2'h0;
            dac_two_range   <= 2'h0;
            gain_amplifier  <= 8'h01;
            offset_sign     <= 1'b0;
            offset_mag      <= 7'h00;
            ref_internal    <= 1'b1;
            ref_high        <= 1'b1;
            filter_sel      <= FLT_FAST;
            gpio_out        <= 8'h00;
            gpio_oe         <= 8'h00;
        end else begin
            temp_diode_en   <= mux == MUX_TEMP;
            pos_sel         <= mux[7:4];
            neg_sel         <= mux[3:0];
            burnout_source  <= analog_control_reg[ANA_BURN];
            burnout_sink    <= analog_control_reg[ANA_BURN];
            input_buffer_en <= gate_s2[0] & setup[SETUP_BUF];
            current_dac_one <= dac1_code;
            current_dac_two <= dac2_code;
            dac_one_range   <= analog_control_reg[ANA_R1_LSB +: 2];
            dac_two_range   <= analog_control_reg[ANA_R2_LSB +: 2];
            // gain is two to the code
            gain_amplifier  <= 8'h01 << analog_control_reg[2:0];
            offset_sign     <= input_offset_shift[7];
            offset_mag      <= input_offset_shift[6:0];
            ref_internal    <= setup[SETUP_REF_EN];
            ref_high        <= setup[SETUP_REF_HI];
            filter_sel      <= next_filter;
            gpio_out        <= pin_value_reg & ~dir;
            gpio_oe         <= ~dir;
        end
    end
endmodule

// [logic/afe_host.sv]
// controller end: apb registers driving the device link
`timescale 1ns/1ps
module afe_host
    import afe_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    afe_link_if.ctl          link
);
    logic [2:0] int_stat, int_en, events;
    logic [7:0] last_rdata;
    logic       cal_advised;
    logic       busy_d;
    logic       acc;
    logic       op_wr;
    logic       refuse;
    logic       mapped;

    assign acc    = psel && penable && pready;
    assign op_wr  = acc && pwrite && paddr == APB_OP;
    assign refuse = op_wr && pwdata[13:12] == OP_WRITE && pwdata[11:8] == ADDR_OFS
                    && link.cal_busy;
    assign mapped = paddr == APB_OP || paddr == APB_STATUS || paddr == APB_ISTAT
                    || paddr == APB_ICLR || paddr == APB_IEN;
    assign events = {refuse, link.reg_rvalid, busy_d && !link.cal_busy};

    // apb answer one cycle into access
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            prdata  <= 32'h0000_0000;
            if (psel && penable && !pready && !pwrite) begin
                unique case (paddr)
                    APB_STATUS: prdata <= {16'h0000, last_rdata, 4'h0, cal_advised,
                                           link.result_discard, link.ready_n, link.cal_busy};
                    APB_ISTAT:  prdata <= {29'h0, int_stat};
                    APB_IEN:    prdata <= {29'h0, int_en};
                    default:    prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // link requests, one cycle pulses
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            link.reg_wr    <= 1'b0;
            link.reg_rd    <= 1'b0;
            link.cmd_valid <= 1'b0;
            link.reg_addr  <= 4'h0;
            link.reg_wdata <= 8'h00;
            link.cmd_code  <= 3'h0;
        end else begin
            link.reg_wr    <= op_wr && pwdata[13:12] == OP_WRITE && !refuse;
            link.reg_rd    <= op_wr && pwdata[13:12] == OP_READ;
            link.cmd_valid <= op_wr && pwdata[13:12] == OP_CMD;
            if (op_wr) begin
                link.reg_addr  <= pwdata[11:8];
                link.reg_wdata <= pwdata[7:0];
                link.cmd_code  <= pwdata[2:0];
            end
        end
    end

    // advise calibration after reset or gain, rate change
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cal_advised <= 1'b1;
            busy_d      <= 1'b0;
            last_rdata  <= 8'h00;
        end else begin
            busy_d <= link.cal_busy;
            if (link.reg_rvalid) begin
                last_rdata <= link.reg_rdata;
            end
            if (link.reg_wr && (link.reg_addr == ADDR_ANA || link.reg_addr == ADDR_DEC0
                                || link.reg_addr == ADDR_DEC1)) begin
                cal_advised <= 1'b1;
            end else if (events[EV_CAL]) begin
                cal_advised <= 1'b0;
            end
        end
    end

    // sticky events, set wins over clear
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            int_stat <= 3'h0;
            int_en   <= 3'h0;
            irq      <= 1'b0;
        end else begin
            if (acc && pwrite && paddr == APB_IEN) begin
                int_en <= pwdata[2:0];
            end
            if (acc && pwrite && paddr == APB_ICLR) begin
                int_stat <= (int_stat & ~pwdata[2:0]) | events;
            end else begin
                int_stat <= int_stat | events;
            end
            irq <= |(int_stat & int_en);
        end
    end
endmodule

// [tb/afe_link_monitor.sv]
// concurrent checks on the controller to device link
`timescale 1ns/1ps
module afe_link_monitor (
    input wire logic       ref_clk,
    input wire logic       reset_n,
    input wire logic       reg_rd,
    input wire logic       reg_rvalid,
    input wire logic       cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic       cal_busy,
    input wire logic       ready_n
);
    logic [31:0] busy_cnt;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    // cycles spent calibrating
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_cnt <= 32'h0;
        end else if (!cal_busy) begin
            busy_cnt <= 32'h0;
        end else begin
            busy_cnt <= busy_cnt + 32'h1;
        end
    end
    sequence s_cal_cmd;
        cmd_valid && (cmd_code <= 3'h4) && !cal_busy;
    endsequence
    sequence s_cal_start;
        s_cal_cmd ##1 cal_busy;
    endsequence
    chk_rvalid_after_rd: assert property (reg_rd |=> reg_rvalid)
        else $error("read answer missing");
    chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read answer without request");
    chk_cmd_starts_cal: assert property (s_cal_cmd |=> cal_busy)
        else $error("calibration did not start");
    chk_cal_min_hold: assert property (s_cal_start |-> cal_busy[*8])
        else $error("calibration ended at once");
    chk_cal_min_len: assert property ($fell(cal_busy) |-> busy_cnt >= 32'h300)
        else $error("calibration too short");
    chk_done_ready_low: assert property ($fell(cal_busy) |-> !ready_n)
        else $error("ready not low at calibration end");
    chk_busy_ready_high: assert property (cal_busy && $past(cal_busy) |-> ready_n)
        else $error("ready low during calibration");
    chk_taken_clears: assert property (
        cmd_valid && cmd_code == 3'h5 && !cal_busy |=> ready_n)
        else $error("ready not released after data taken");
endmodule

// [tb/tb_top.sv]
// self-checking bench for the front-end controller and device pair
`timescale 1ns/1ps
module tb_top;
    import afe_pkg::*;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, irq, err;
    logic        gate = 1'b0;
    logic [7:0]  ext = 8'h3C;
    logic [7:0]  gpio_out, gpio_oe, dac1, dac2, gain;
    logic [3:0]  pos_sel, neg_sel;
    logic [1:0]  rng1, rng2, flt;
    logic [6:0]  o_mag;
    logic        temp_en, bo_src, bo_snk, buf_en, o_sign, mod_clk, ref_int, ref_hi, rdy_n;
    int          fail_count = 0;
    int          n_tests = 0;
    wire  [7:0]  gpio_in = (gpio_out & gpio_oe) | (ext & ~gpio_oe);
    always #4 ref_clk = ~ref_clk;
    afe_link_if lnk (.ref_clk(ref_clk), .reset_n(reset_n));
    afe_host i_afe_host (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .link(lnk));
    afe_device i_afe_device (.ref_clk(ref_clk), .reset_n(reset_n), .link(lnk),
        .buffer_gate_pin(gate), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .temp_diode_en(temp_en), .pos_sel(pos_sel), .neg_sel(neg_sel),
        .burnout_source(bo_src), .burnout_sink(bo_snk), .input_buffer_en(buf_en),
        .current_dac_one(dac1), .current_dac_two(dac2), .dac_one_range(rng1),
        .dac_two_range(rng2), .gain_amplifier(gain), .offset_sign(o_sign),
        .offset_mag(o_mag), .modulator_clock(mod_clk), .ref_internal(ref_int),
        .ref_high(ref_hi), .filter_sel(flt), .conversion_ready_n(rdy_n));
    afe_link_monitor i_afe_link_monitor (.ref_clk(ref_clk), .reset_n(reset_n),
        .reg_rd(lnk.reg_rd), .reg_rvalid(lnk.reg_rvalid), .cmd_valid(lnk.cmd_valid),
        .cmd_code(lnk.cmd_code), .cal_busy(lnk.cal_busy), .ready_n(lnk.ready_n));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic op(input logic [1:0] k, input logic [3:0] a, input logic [7:0] d);
        apb(1'b1, APB_OP, {18'h0, k, a, d});
        repeat (6) @(posedge ref_clk);
    endtask
    task automatic wait_rdy(input logic lvl);
        for (int i = 0; i < 2000 && lnk.ready_n !== lvl; i++) @(posedge ref_clk);
        chk("ready wait", lnk.ready_n, lvl);
    endtask
    task automatic t_pins;
        op(OP_WRITE, ADDR_MUX, 8'hFF);
        chk("diode", temp_en, 1);
        op(OP_WRITE, ADDR_MUX, 8'h37);
        chk("pair", {temp_en, pos_sel, neg_sel}, 9'h037);
        for (int g = 0; g < 8; g++) begin
            op(OP_WRITE, ADDR_ANA, {3'h5, 2'h1, 3'(g)});
            chk("analog", {bo_src, bo_snk, rng2, rng1, gain}, {6'h35, 8'(1 << g)});
        end
        op(OP_WRITE, ADDR_ANA, 8'h00);
        chk("no burnout", {bo_src, bo_snk}, 0);
        op(OP_WRITE, ADDR_DAC1, 8'h5A);
        op(OP_WRITE, ADDR_DAC2, 8'hA5);
        chk("dacs", {dac1, dac2}, 16'h5AA5);
        op(OP_WRITE, ADDR_SETUP, 8'h02);
        chk("ext ref", {ref_int, ref_hi, buf_en}, 0);
        gate <= 1'b1;
        repeat (5) @(posedge ref_clk);
        chk("buffer on", buf_en, 1);
        op(OP_WRITE, ADDR_SETUP, 8'h08);
        chk("low ref", {ref_int, ref_hi, buf_en}, 3'h4);
        op(OP_WRITE, ADDR_DIR, 8'h0F);
        op(OP_WRITE, ADDR_PVAL, 8'hA5);
        chk("pin drive", {gpio_oe, gpio_out}, 16'hF0A0);
        op(OP_READ, ADDR_PVAL, 8'h00);
        apb(1'b0, APB_STATUS, 32'h0);
        chk("pin sense", rd[15:8], 8'hAC);
        apb(1'b1, 8'h14, 32'h0);
        chk("unmapped", err, 1);
    endtask
    task automatic t_mod;
        int n;
        for (int s = 1; s >= 0; s--) begin
            op(OP_WRITE, ADDR_SETUP, {3'h0, 1'(s), 4'hC});
            repeat (2) begin
                while (mod_clk !== 1'b1) @(posedge ref_clk);
                n = 0;
                do begin @(posedge ref_clk); n++; end while (mod_clk !== 1'b1 && n < 600);
            end
            chk("mod div", n, s ? 256 : 128);
        end
    endtask
    task automatic t_cal;
        int n;
        int p;
        op(OP_WRITE, ADDR_DEC0, 8'h02);
        op(OP_WRITE, ADDR_DEC1, 8'h10);
        apb(1'b1, APB_ICLR, 32'h7);
        apb(1'b0, APB_STATUS, 32'h0);
        chk("advise", rd[3], 1);
        for (int k = 0; k < 5; k++) begin
            p = (k == 0) ? 14 : 7;
            apb(1'b1, APB_IEN, 32'(k < 4));
            op(OP_WRITE, ADDR_OFS, 8'h85);
            chk("ofs", {o_sign, o_mag}, 8'h85);
            apb(1'b1, APB_OP, {18'h0, OP_CMD, 9'h0, 3'(k)});
            repeat (3) @(posedge ref_clk);
            if (k == 0) op(OP_WRITE, ADDR_OFS, 8'h33);
            n = 0;
            while (lnk.cal_busy !== 1'b0 && n < 4000) begin @(posedge ref_clk); n++; end
            chk("cal len", 32'(n > (p - 1) * 256 - 24 && n <= p * 256 + 8), 1);
            repeat (2) @(posedge ref_clk);
            chk("cal done", {rdy_n, o_sign, o_mag}, 0);
            apb(1'b0, APB_ISTAT, 32'h0);
            chk("istat", rd & 32'h5, k == 0 ? 5 : 1);
            apb(1'b0, APB_STATUS, 32'h0);
            chk("status", rd[3:0], 4'h0);
            chk("irq", irq, k < 4);
            apb(1'b1, APB_ICLR, 32'h7);
            repeat (2) @(posedge ref_clk);
            chk("irq clr", irq, 0);
        end
    endtask
    task automatic t_filter;
        for (int m = 1; m < 4; m++) begin
            op(OP_WRITE, ADDR_DEC1, {2'h0, 2'(m), 4'h0});
            chk("filter", flt, m);
        end
        op(OP_WRITE, ADDR_DEC1, 8'h00);
        apb(1'b1, APB_OP, {18'h0, OP_CMD, 12'h005});
        wait_rdy(1'b1);
        wait_rdy(1'b0);
        op(OP_WRITE, ADDR_MUX, 8'h12);
        chk("auto start", flt, FLT_FAST);
        for (int t = 1; t < 4; t++) begin
            apb(1'b1, APB_OP, {18'h0, OP_CMD, 12'h005});
            wait_rdy(1'b1);
            wait_rdy(1'b0);
            repeat (2) @(posedge ref_clk);
            chk("auto seq", flt, t == 1 ? FLT_FAST : (t == 2 ? FLT_SINC2 : FLT_SINC3));
            chk("discard", lnk.result_discard, t == 1);
        end
    endtask
    initial begin
        repeat (40000) @(posedge ref_clk);
        fail_count++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        chk("reset", {ref_int, ref_hi, gpio_oe, gain, rdy_n}, 19'h60003);
        t_pins();
        t_mod();
        t_cal();
        t_filter();
        summarize();
    end
endmodule
